/* File: rtl/scoc_params.svh */
// scoc_params.svh: offsets, field positions and reset values for the sensor config one register
// assumes: included by the package and the design file by bare name
`ifndef SCOC_PARAMS_SVH
`define SCOC_PARAMS_SVH

`define SCOC_ADDR_W            8
`define SCOC_OFFSET            8'h15
`define SCOC_BIT_ACTIVE        0
`define SCOC_BIT_RANGE_LO      1
`define SCOC_BIT_RANGE_HI      2
`define SCOC_BIT_WIRE_MODE     3
`define SCOC_BIT_POLARITY      4
`define SCOC_BIT_AXIS_LO       5
`define SCOC_BIT_AXIS_HI       6
`define SCOC_RESET_VALUE       8'h02
`define SCOC_RANGE_2G          2'h0
`define SCOC_RANGE_4G          2'h1
`define SCOC_RANGE_8G          2'h2
`define SCOC_RANGE_16G         2'h3
`define SCOC_SENS_2G           11'h400
`define SCOC_SENS_4G           11'h200
`define SCOC_SENS_8G           11'h100
`define SCOC_SENS_16G          11'h080

`endif

/* File: rtl/scoc_pkg.sv */
// scoc_pkg.sv: types for the sensor config one control block
// assumes: scoc_params.svh on the include path
`include "scoc_params.svh"
package scoc_pkg;
    // operating mode seen by the sensing core
    typedef enum logic [1:0] {
        SCOC_STANDBY,
        SCOC_ACTIVE_RUN
    } scoc_mode_t;

    // self-test axis drive choice
    typedef enum logic [1:0] {
        SCOC_ST_OFF,
        SCOC_ST_X,
        SCOC_ST_Y,
        SCOC_ST_Z
    } scoc_axis_t;
endpackage

/* File: rtl/scoc_sensor_config_one.sv */
// scoc_sensor_config_one.sv: sensor config one register and its control outputs
// assumes: the serial front end gives one-cycle write/read strobes with an address,
// a transaction-end pulse, and drives pins from the wire-mode outputs here
//
// Functional notes
// RL1: polarity bit 0 drives the proof mass positive, 1 drives it negative, default 0.
// RL2: wire-count bit 0 selects 4-wire, 1 selects 3-wire, default 0.
// RL3: the wire-count bit only matters with the interface pin choosing SPI, ignored in I2C.
// RL4: SPI with 3-wire set makes MOSI bidirectional and floats the MISO pin.
// RL5: power-on, brown-out reset and hibernate exit restore 4-wire mode.
// RL6: with SPI and MOSI/MISO joined on the board, 3-wire runs whatever the bit holds.
// RL7: range 00 is 2 g at 1024, 01 (default) 4 g at 512, 10 8 g at 256, 11 16 g at 128 LSB/g.
// RL8: with pin run control enabled the active bit is read-only and the pin sets the mode.
// RL9: the host enables pin run control only while the active bit is 0.
// RL10: the host sets the active bit only while pin run control is disabled.
// RL11: active 0 is minimum-current standby, 1 measures with the configured settings.
// RL12: power-on and soft reset leave the device in standby with active cleared.
// RL13: axis field 00 disables self-test, 01/10/11 enable X/Y/Z, default 00.
// RL14: a wire-mode change applies from the transaction after the one that wrote it.
`timescale 1ns/1ps
`include "scoc_params.svh"

module scoc_sensor_config_one (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // reset and power events
    input  wire logic                     soft_reset,
    input  wire logic                     hibernate_exit,
    // register port from the serial front end
    input  wire logic [`SCOC_ADDR_W-1:0]  reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    output logic                          reg_hit,
    input  wire logic                     xfer_end,
    // pins and straps
    input  wire logic                     interface_choice_pin,
    input  wire logic                     mosi_miso_joined,
    input  wire logic                     second_irq_pin,
    input  wire logic                     second_irq_pin_run_control,
    // spi pad steering
    output logic                          spi_three_wire,
    output logic                          address_lsb_or_miso_pin_oe_en,
    output logic                          mosi_bidir_en,
    // sensing core controls
    output logic                          measure_active,
    output scoc_pkg::scoc_mode_t          op_mode,
    output logic                          selftest_drive_polarity,
    output scoc_pkg::scoc_axis_t          selftest_axis_choice,
    output logic      [1:0]               range_scale_select,
    output logic      [10:0]              range_lsb_per_g
);

    // register fields
    logic [1:0]  axis_q;
    logic        pol_q;
    logic        wire_bit_q;
    logic [1:0]  range_q;
    logic        active_q;
    logic        wire_live_q;
    logic        wire_live_d;
    logic [10:0] sens_q;
    logic [7:0]  rdata_q;

    // address decode and write qualification
    wire sel_hit      = (reg_addr == `SCOC_OFFSET);
    wire wr_hit       = reg_wr && sel_hit;
    wire active_lock  = second_irq_pin_run_control;                              // RL8
    wire spi_chosen   = interface_choice_pin;                                    // RL3
    wire active_eff   = active_lock ? second_irq_pin : active_q;                 // RL8
    wire three_wanted = spi_chosen && (wire_bit_q || mosi_miso_joined);          // RL3 RL6
    wire [7:0] reg_view = {1'b0, axis_q, pol_q, wire_bit_q, range_q, active_eff};

    // sensitivity lookup for the range field
    function automatic logic [10:0] lsb_per_g(input logic [1:0] r);
        case (r)
            `SCOC_RANGE_2G: lsb_per_g = `SCOC_SENS_2G;                          // RL7
            `SCOC_RANGE_4G: lsb_per_g = `SCOC_SENS_4G;
            `SCOC_RANGE_8G: lsb_per_g = `SCOC_SENS_8G;
            default:        lsb_per_g = `SCOC_SENS_16G;
        endcase
    endfunction

    // configuration fields; soft reset restores defaults and standby
    always_ff @(posedge core_clk) begin
        if (!rst_n || soft_reset) begin
            axis_q     <= 2'h0;                                                  // RL13
            pol_q      <= 1'b0;                                                  // RL1
            wire_bit_q <= 1'b0;                                                  // RL2 RL5
            range_q    <= 2'h1;                                                  // RL7
            active_q   <= 1'b0;                                                  // RL12
        end else if (wr_hit) begin
            axis_q     <= reg_wdata[`SCOC_BIT_AXIS_HI:`SCOC_BIT_AXIS_LO];        // RL13
            pol_q      <= reg_wdata[`SCOC_BIT_POLARITY];                         // RL1
            wire_bit_q <= reg_wdata[`SCOC_BIT_WIRE_MODE];                        // RL2
            range_q    <= reg_wdata[`SCOC_BIT_RANGE_HI:`SCOC_BIT_RANGE_LO];      // RL7
            if (!active_lock) begin
                active_q <= reg_wdata[`SCOC_BIT_ACTIVE];                         // RL8 RL10
            end
        end
        if (rst_n && !soft_reset && hibernate_exit) begin
            wire_bit_q <= 1'b0;                                                  // RL5
        end
    end

    // live wire mode follows the setting only at transaction boundaries; reset and hibernate exit clear it at once
    assign wire_live_d = xfer_end ? three_wanted : wire_live_q;                  // RL14

    always_ff @(posedge core_clk) begin
        if (!rst_n || hibernate_exit) begin
            wire_live_q <= 1'b0;                                                 // RL5
        end else begin
            wire_live_q <= wire_live_d;
        end
    end

    // registered read data and sensitivity
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            sens_q  <= `SCOC_SENS_4G;
        end else begin
            rdata_q <= (reg_rd && sel_hit) ? reg_view : 8'h00;
            sens_q  <= lsb_per_g(range_q);                                       // RL7
        end
    end

    // outputs
    assign reg_rdata                     = rdata_q;
    assign reg_hit                       = sel_hit;
    assign spi_three_wire                = wire_live_q;                          // RL4
    assign mosi_bidir_en                 = wire_live_q;                          // RL4
    assign address_lsb_or_miso_pin_oe_en = spi_chosen && !wire_live_q;          // RL4
    assign measure_active                = active_eff;                           // RL11
    assign op_mode = active_eff ? scoc_pkg::SCOC_ACTIVE_RUN : scoc_pkg::SCOC_STANDBY; // RL11
    assign selftest_drive_polarity       = pol_q;                                // RL1
    assign selftest_axis_choice          = scoc_pkg::scoc_axis_t'(axis_q);       // RL13
    assign range_scale_select            = range_q;                              // RL7
    assign range_lsb_per_g               = sens_q;

endmodule // scoc_sensor_config_one

/* File: bench/scoc_host_model.sv */
// scoc_host_model.sv: host side of the serial register port
// assumes: the bench calls xfer; one-cycle strobes on a 125 MHz core clock
`timescale 1ns/1ps
module scoc_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr, reg_rd, xfer_end,
    output logic      [7:0] reg_addr, reg_wdata
);
    initial {reg_wr, reg_rd, xfer_end, reg_addr, reg_wdata} = '0;
    // strobe, take the answer, then end the transaction; idle data is scrambled
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge core_clk) #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge core_clk) #1 q = reg_rdata;
        {reg_wr, reg_rd, xfer_end, reg_wdata} = {3'b001, ~d};
        @(posedge core_clk) #1 xfer_end = 0;
    endtask
endmodule // scoc_host_model

/* File: bench/scoc_chk.sv */
// scoc_chk.sv: port assertions for the sensor config one block
// assumes: bound into scoc_sensor_config_one by the bench
`timescale 1ns/1ps
module scoc_chk (
    input wire logic core_clk, rst_n, soft_reset, hibernate_exit, xfer_end, interface_choice_pin,
    input wire logic mosi_miso_joined, second_irq_pin, second_irq_pin_run_control,
    input wire logic spi_three_wire, mosi_bidir_en, address_lsb_or_miso_pin_oe_en, measure_active,
    input wire logic [1:0]  range_scale_select,
    input wire logic [10:0] range_lsb_per_g,
    input wire scoc_pkg::scoc_mode_t op_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // pad steering, mode and scale relations
    miso_float_a: assert property (
        address_lsb_or_miso_pin_oe_en == (interface_choice_pin && !spi_three_wire))
        else $error("miso enable wrong");
    bidir_data_a: assert property (mosi_bidir_en == spi_three_wire) else $error("bidir wrong");
    pin_mode_a: assert property (second_irq_pin_run_control |-> measure_active == second_irq_pin)
        else $error("pin mode wrong");
    op_mode_a: assert property (
        op_mode == (measure_active ? scoc_pkg::SCOC_ACTIVE_RUN : scoc_pkg::SCOC_STANDBY))
        else $error("op mode wrong");
    range_lsb_a: assert property (
        $past(rst_n) |-> range_lsb_per_g == (11'h400 >> $past(range_scale_select)))
        else $error("lsb per g wrong");
    wire_hold_a: assert property (
        !xfer_end && !hibernate_exit && !soft_reset && $stable(mosi_miso_joined)
        && $stable(interface_choice_pin) |=> $stable(spi_three_wire))
        else $error("wire mode moved");
    hib_four_a: assert property (
        hibernate_exit && !mosi_miso_joined |=> !spi_three_wire)
        else $error("hibernate");
    soft_standby_a: assert property (soft_reset |=> !measure_active || second_irq_pin_run_control)
        else $error("soft reset active");
    // main scenarios
    three_wire_c: cover property ($rose(spi_three_wire));
    pin_run_c: cover property (second_irq_pin_run_control && measure_active);
    soft_c: cover property (soft_reset);
endmodule // scoc_chk

/* File: bench/scoc_sensor_config_one_tb.sv */
// scoc_sensor_config_one_tb.sv: self-checking bench for the sensor config one register
// assumes: scoc_host_model drives the register port; scoc_chk is bound at the foot
`timescale 1ns/1ps
module scoc_sensor_config_one_tb;
    logic core_clk, rst_n, soft_reset, hib, intf, joined, irq, rctl, wr_s, rd_s, xe;
    logic three_w, oe, bidir, act, pol;
    logic [7:0] addr, wdata, rdata, q;
    logic [1:0] rng;
    logic [10:0] lsb;
    scoc_pkg::scoc_mode_t mode;
    scoc_pkg::scoc_axis_t axis;
    int num_errors = 0, check_count = 0, cyc = 0;
    scoc_host_model scoc_host_model_i (.core_clk, .reg_rdata(rdata), .reg_wr(wr_s), .reg_rd(rd_s),
        .xfer_end(xe), .reg_addr(addr), .reg_wdata(wdata));
    scoc_sensor_config_one scoc_sensor_config_one_i (.core_clk, .rst_n, .soft_reset,
        .hibernate_exit(hib), .reg_addr(addr), .reg_wr(wr_s), .reg_wdata(wdata), .reg_rd(rd_s),
        .reg_rdata(rdata), .reg_hit(), .xfer_end(xe), .interface_choice_pin(intf),
        .mosi_miso_joined(joined), .second_irq_pin(irq), .second_irq_pin_run_control(rctl),
        .spi_three_wire(three_w), .address_lsb_or_miso_pin_oe_en(oe), .mosi_bidir_en(bidir),
        .measure_active(act), .op_mode(mode), .selftest_drive_polarity(pol),
        .selftest_axis_choice(axis), .range_scale_select(rng), .range_lsb_per_g(lsb));
    // clock and hang guard
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (++cyc == 2000) begin
        num_errors++;
        finish_test();
    end
    task automatic chk(string n, logic [10:0] g, e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, d);
        scoc_host_model_i.xfer(1, a, d, q);
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk) #1 s = 1;
        @(posedge core_clk) #1 s = 0;
    endtask
    task automatic finish_test();
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // reset, then register, pin and mode scenarios
    initial begin
        {soft_reset, hib, intf, joined, irq, rctl, rst_n} = '0;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1;
        scoc_host_model_i.xfer(0, 8'h15, 8'h00, q);
        chk("reset value", q, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(8'h15, 8'(i * 34 + 16));
            chk("range", rng, 11'(i));
            chk("lsb per g", lsb, 11'h400 >> i);
            chk("axis", axis, 11'(i));
            chk("polarity", pol, 1);
        end
        scoc_host_model_i.xfer(0, 8'h15, 8'h00, q);
        chk("read back", q, 8'h76);
        wr(8'h15, 8'h01);
        chk("op mode", mode, scoc_pkg::SCOC_ACTIVE_RUN);
        intf = 1;
        wr(8'h15, 8'h09);
        chk("miso enable", oe, 0);
        chk("bidir", bidir, 1);
        pulse(hib);
        chk("three wire", three_w, 0);
        intf = 0;
        wr(8'h15, 8'h08);
        chk("bidir i2c", bidir, 0);
        {intf, joined} = 2'b11;
        wr(8'h15, 8'h00);
        chk("joined", three_w, 1);
        {joined, rctl, irq} = 3'b011;
        wr(8'h15, 8'h00);
        chk("pin active", act, 1);
        irq = 0;
        #8 chk("pin standby", act, 0);
        rctl = 0;
        wr(8'h15, 8'h0D);
        pulse(soft_reset);
        chk("soft reset", act, 0);
        finish_test();
    end
endmodule // scoc_sensor_config_one_tb
bind scoc_sensor_config_one scoc_chk scoc_chk_i (.*);
